// [src/nvm_seq_pkg.sv]
package nvm_seq_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [15:0] BASE_ADDR   = 16'h01C0;
   localparam logic [4:0]  OFS_CMD     = 5'h00;
   localparam logic [4:0]  OFS_MEMORY_CONTROL_A   = 5'h04;
   localparam logic [4:0]  OFS_STATUS  = 5'h08;
   localparam logic [4:0]  OFS_DATA    = 5'h0C;
   localparam logic [4:0]  OFS_ADDR    = 5'h10;
   localparam logic [4:0]  OFS_INTFLAG = 5'h14;
   localparam logic [4:0]  OFS_INTMASK = 5'h18;
   localparam logic [4:0]  OFS_CCP     = 5'h1C;
   localparam int          EXEC_BIT    = 0;
   localparam int          BUSY_BIT    = 0;
   localparam int          MEMEN_BIT   = 1;
   localparam int          INT_DONE    = 0;
   localparam int          INT_REJECT  = 1;
   localparam logic [6:0]  CMD_RESET   = 7'h00;
   localparam logic [15:0] ADDR_RESET  = 16'h0000;
   localparam logic [31:0] DATA_RESET  = 32'h0000_0000;
   localparam logic [1:0]  INT_RESET   = 2'h0;

   // ---------------------------------------------------------------
   // memory layout
   // ---------------------------------------------------------------
   localparam int          PAGE_AW     = 5;
   localparam int          MEM_AW      = 11;
   localparam int          MEM_DEPTH   = 1568;
   localparam logic [10:0] APP_BASE    = 11'h000;
   localparam logic [10:0] APP_LAST    = 11'h3FF;
   localparam logic [10:0] BOOT_BASE   = 11'h400;
   localparam logic [10:0] BOOT_LAST   = 11'h4FF;
   localparam logic [10:0] EEP_BASE    = 11'h500;
   localparam logic [10:0] EEP_LAST    = 11'h5FF;
   localparam logic [10:0] USIG_BASE   = 11'h600;
   localparam logic [10:0] USIG_LAST   = 11'h61F;
   localparam logic [10:0] PAGE_LAST   = 11'h01F;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;

   // ---------------------------------------------------------------
   // command codes
   // ---------------------------------------------------------------
   localparam logic [6:0]  CMD_ER_APP_PG   = 7'h22;
   localparam logic [6:0]  CMD_ER_BOOT_PG  = 7'h2A;
   localparam logic [6:0]  CMD_ER_EEP_PG   = 7'h32;
   localparam logic [6:0]  CMD_ER_USIG     = 7'h18;
   localparam logic [6:0]  CMD_WR_APP_PG   = 7'h24;
   localparam logic [6:0]  CMD_WR_BOOT_PG  = 7'h2C;
   localparam logic [6:0]  CMD_WR_EEP_PG   = 7'h34;
   localparam logic [6:0]  CMD_WR_USIG     = 7'h1A;
   localparam logic [6:0]  CMD_EW_APP_PG   = 7'h25;
   localparam logic [6:0]  CMD_EW_BOOT_PG  = 7'h2D;
   localparam logic [6:0]  CMD_EW_EEP_PG   = 7'h35;
   localparam logic [6:0]  CMD_ER_APP_SEC  = 7'h20;
   localparam logic [6:0]  CMD_ER_BOOT_SEC = 7'h68;
   localparam logic [6:0]  CMD_ER_EEP_SEC  = 7'h30;
   localparam logic [6:0]  CMD_CRC_APP     = 7'h38;
   localparam logic [6:0]  CMD_CRC_BOOT    = 7'h39;
   localparam logic [6:0]  CMD_CRC_FLASH   = 7'h78;
   localparam logic [6:0]  CMD_WR_FUSE     = 7'h4C;
   localparam logic [6:0]  CMD_WR_LOCK     = 7'h08;

   // ---------------------------------------------------------------
   // crc, fuses, protection window
   // ---------------------------------------------------------------
   localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
   localparam logic [7:0]  FUSE_RESET  = 8'hFF;
   localparam logic [2:0]  LOCK_IDX    = 3'h7;
   localparam logic [7:0]  CCP_KEY     = 8'h9D;
   localparam int          CLK_NS      = 10;
   localparam int          CCP_WIN_NS  = 40;
   localparam logic [3:0]  CCP_WIN_CYC = 4'(CCP_WIN_NS / CLK_NS);

   typedef enum {OP_NONE, OP_ERASE, OP_WRITE, OP_ERWR, OP_CRC, OP_FUSE} opkind_type;
   typedef enum {S_IDLE, S_ERASE, S_BUFREQ, S_BUFWR, S_CRCREQ, S_CRCACC, S_FUSE} state_type;

endpackage : nvm_seq_pkg

// [src/nvm_mem_if.sv]
`timescale 1ns/10ps
interface nvm_mem_if #(parameter int AW = 11);
   logic          wrEn;
   logic          rdEn;
   logic [AW-1:0] addr;
   logic [7:0]    wrData;
   logic [7:0]    rdData;
   modport ctrl  (output wrEn, rdEn, addr, wrData, input rdData);
   modport store (input wrEn, rdEn, addr, wrData, output rdData);
endinterface : nvm_mem_if

// [src/nvm_store.sv]
`timescale 1ns/10ps
module nvm_store #(
   parameter int AW    = 11,
   parameter int DEPTH = 1568
) (
   input wire logic sys_clk,
   nvm_mem_if.store port
);

   // ---------------------------------------------------------------
   // array with registered read
   // ---------------------------------------------------------------
   // no reset on the cells: contents are meant to survive a reset
   logic [7:0] cells [DEPTH];

   always_ff @(posedge sys_clk) begin
      if (port.wrEn) begin
         cells[port.addr] <= port.wrData;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (port.rdEn) begin
         port.rdData <= cells[port.addr];
      end
   end

endmodule : nvm_store

// [src/nvm_page_command_sequencer.sv]
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// [RULE1] programmer loads the command code before any trigger
// [RULE2] page erases clear one page, started by the execute bit
// [RULE3] page writes copy the loaded page buffer into the chosen page
// [RULE4] page writes start on a debug write; page from address, offset ignored
// [RULE5] erase-and-write erases then programs the page in one operation
// [RULE6] section erases clear the whole section on a debug write
// [RULE7] busy stays high from start until the command completes
// [RULE8] section crc starts on execute; self-programming needs the unlock window
// [RULE9] finished crc lands in the data register
// [RULE10] flash crc ignores lock bits and starts on the execute bit
// [RULE11] flash crc cuts the debug path and clears memory-enabled flag
// [RULE12] programmer polls memory-enabled flag before touching memory again
// [RULE13] fuse and lock writes only move bits toward more secure
// [RULE14] fuse and lock writes start on a debug write to the byte
// [RULE15] register block decodes at base 0x01C0
// [RULE16] page erase codes 0x22, 0x2A, 0x32
// [RULE17] page write codes 0x24, 0x2C, 0x34
// [RULE18] erase-and-write codes 0x25, 0x2D, 0x35
// [RULE19] crc codes 0x38, 0x39, 0x78
module nvm_page_command_sequencer
   import nvm_seq_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               rst_b,
   input  wire logic [15:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               progMode,
   input  wire logic               dbgWrite,
   input  wire logic [15:0]        dbgAddr,
   input  wire logic [7:0]         dbgData,
   output logic      [PAGE_AW-1:0] bufIndex,
   input  wire logic [7:0]         bufData,
   output logic                    memEnabled,
   output logic                    busy,
   output logic                    irq
);

   nvm_mem_if #(.AW(MEM_AW)) mem ();

   nvm_store #(.AW(MEM_AW), .DEPTH(MEM_DEPTH)) u_store (
      .sys_clk (sys_clk),
      .port    (mem)
   );

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   state_type         stateReg;
   state_type         stateNext;
   opkind_type        kindReg;
   logic [6:0]        cmdReg;
   logic [15:0]       addrReg;
   logic [31:0]       dataReg;
   logic [31:0]       crcReg;
   logic [1:0]        intFlagReg;
   logic [1:0]        intMaskReg;
   logic [3:0]        ccpCntReg;
   logic [MEM_AW-1:0] ptrReg;
   logic [MEM_AW-1:0] firstReg;
   logic [MEM_AW-1:0] lastReg;
   logic [2:0]        fuseIdxReg;
   logic [7:0]        fuseDataReg;
   logic [7:0]        fuseReg [8];

   // ---------------------------------------------------------------
   // register bus
   // ---------------------------------------------------------------
   logic        hit;
   logic [4:0]  ofs;
   logic        apbWr;
   logic [31:0] rdMux;

   assign hit   = (paddr[15:5] == BASE_ADDR[15:5]) && (paddr[1:0] == 2'h0); // [RULE15]
   assign ofs   = paddr[4:0];
   assign apbWr = psel && penable && pready && pwrite && hit;

   always_comb begin
      rdMux = 32'h0000_0000;
      case (ofs)
         OFS_CMD:     rdMux = {25'h000_0000, cmdReg};
         OFS_STATUS:  rdMux = {16'h0000, fuseReg[addrReg[2:0]], 6'h00, memEnabled, busy};
         OFS_DATA:    rdMux = dataReg;
         OFS_ADDR:    rdMux = {16'h0000, addrReg};
         OFS_INTFLAG: rdMux = {30'h0000_0000, intFlagReg};
         OFS_INTMASK: rdMux = {30'h0000_0000, intMaskReg};
         default:     rdMux = 32'h0000_0000;
      endcase
   end

   // one wait state: pready rises in the second access cycle
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !hit;
         if (psel && penable && !pready) begin
            prdata <= hit ? rdMux : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmdReg     <= CMD_RESET;
         addrReg    <= ADDR_RESET;
         intMaskReg <= INT_RESET;
      end else if (apbWr) begin
         case (ofs)
            OFS_CMD:     cmdReg     <= pwdata[6:0]; // [RULE1]
            OFS_ADDR:    addrReg    <= pwdata[15:0];
            OFS_INTMASK: intMaskReg <= pwdata[1:0];
            default:     cmdReg     <= cmdReg;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // unlock window for self-programming
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ccpCntReg <= 4'h0;
      end else if (apbWr && ofs == OFS_CCP && pwdata[7:0] == CCP_KEY) begin
         ccpCntReg <= CCP_WIN_CYC;
      end else if (ccpCntReg != 4'h0) begin
         ccpCntReg <= ccpCntReg - 4'h1;
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   opkind_type        opKind;
   logic              opExec;
   logic              opProt;
   logic              opPage;
   logic              opFlash;
   logic [MEM_AW-1:0] opBase;
   logic [MEM_AW-1:0] opLast;

   always_comb begin
      opKind  = OP_NONE;
      opExec  = 1'b0;
      opProt  = 1'b0;
      opPage  = 1'b1;
      opFlash = 1'b0;
      opBase  = APP_BASE;
      opLast  = APP_LAST;
      case (cmdReg)
         CMD_ER_APP_PG:   begin opKind = OP_ERASE; opExec = 1'b1; end // [RULE2] [RULE16]
         CMD_ER_BOOT_PG:  begin opKind = OP_ERASE; opExec = 1'b1; opBase = BOOT_BASE; end // [RULE16]
         CMD_ER_EEP_PG:   begin opKind = OP_ERASE; opExec = 1'b1; opBase = EEP_BASE; end // [RULE16]
         CMD_ER_USIG:     begin opKind = OP_ERASE; opExec = 1'b1; opBase = USIG_BASE; end
         CMD_WR_APP_PG:   opKind = OP_WRITE; // [RULE3] [RULE17]
         CMD_WR_BOOT_PG:  begin opKind = OP_WRITE; opBase = BOOT_BASE; end // [RULE17]
         CMD_WR_EEP_PG:   begin opKind = OP_WRITE; opBase = EEP_BASE; end // [RULE17]
         CMD_WR_USIG:     begin opKind = OP_WRITE; opBase = USIG_BASE; end
         CMD_EW_APP_PG:   opKind = OP_ERWR; // [RULE5] [RULE18]
         CMD_EW_BOOT_PG:  begin opKind = OP_ERWR; opBase = BOOT_BASE; end // [RULE18]
         CMD_EW_EEP_PG:   begin opKind = OP_ERWR; opBase = EEP_BASE; end // [RULE18]
         CMD_ER_APP_SEC:  begin opKind = OP_ERASE; opPage = 1'b0; end // [RULE6]
         CMD_ER_BOOT_SEC: begin
            opKind = OP_ERASE; opPage = 1'b0; opBase = BOOT_BASE; opLast = BOOT_LAST; // [RULE6]
         end
         CMD_ER_EEP_SEC:  begin
            opKind = OP_ERASE; opPage = 1'b0; opBase = EEP_BASE; opLast = EEP_LAST; // [RULE6]
         end
         CMD_CRC_APP:     begin
            opKind = OP_CRC; opExec = 1'b1; opProt = 1'b1; opPage = 1'b0; // [RULE8] [RULE19]
         end
         CMD_CRC_BOOT:    begin
            opKind = OP_CRC; opExec = 1'b1; opProt = 1'b1; opPage = 1'b0; // [RULE8] [RULE19]
            opBase = BOOT_BASE; opLast = BOOT_LAST;
         end
         // lock bits are never consulted, so flash crc runs whatever they hold
         CMD_CRC_FLASH:   begin
            opKind = OP_CRC; opExec = 1'b1; opProt = 1'b1; opPage = 1'b0; // [RULE10] [RULE19]
            opFlash = 1'b1; opLast = BOOT_LAST;
         end
         CMD_WR_FUSE:     opKind = OP_FUSE; // [RULE14]
         CMD_WR_LOCK:     opKind = OP_FUSE; // [RULE14]
         default:         opKind = OP_NONE;
      endcase
   end

   // ---------------------------------------------------------------
   // triggers
   // ---------------------------------------------------------------
   logic              idle;
   logic              execHit;
   logic              dbgHit;
   logic              unlocked;
   logic              start;
   logic              rejectEv;
   logic              doneEv;
   logic [15:0]       srcAddr;
   logic [MEM_AW-1:0] pageFirst;
   logic              atLast;

   assign idle     = (stateReg == S_IDLE);
   assign execHit  = apbWr && ofs == OFS_MEMORY_CONTROL_A && pwdata[EXEC_BIT] && opExec;
   // debug path is cut while flash crc owns the array
   assign dbgHit   = dbgWrite && memEnabled && !opExec; // [RULE11] [RULE4] [RULE6] [RULE14]
   assign unlocked = !opProt || progMode || (ccpCntReg != 4'h0); // [RULE8]
   assign start    = idle && opKind != OP_NONE && ((execHit && unlocked) || dbgHit); // [RULE2] [RULE10]
   assign rejectEv = opKind != OP_NONE && (execHit || dbgHit) && !start;
   assign doneEv   = !idle && stateNext == S_IDLE;
   assign srcAddr  = execHit ? addrReg : dbgAddr;
   // page chosen by the address, byte offset dropped; caller keeps it inside the section
   assign pageFirst = opBase + {srcAddr[MEM_AW-1:PAGE_AW], {PAGE_AW{1'b0}}}; // [RULE4]
   assign atLast    = (ptrReg == lastReg);

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_comb begin
      stateNext = stateReg;
      case (stateReg)
         S_IDLE: begin
            if (start) begin
               case (opKind)
                  OP_ERASE: stateNext = S_ERASE;
                  OP_ERWR:  stateNext = S_ERASE;
                  OP_WRITE: stateNext = S_BUFREQ;
                  OP_CRC:   stateNext = S_CRCREQ;
                  OP_FUSE:  stateNext = S_FUSE;
                  default:  stateNext = S_IDLE;
               endcase
            end
         end
         S_ERASE: begin
            if (atLast) begin
               stateNext = (kindReg == OP_ERWR) ? S_BUFREQ : S_IDLE; // [RULE5]
            end
         end
         S_BUFREQ: stateNext = S_BUFWR;
         S_BUFWR:  stateNext = atLast ? S_IDLE : S_BUFREQ;
         S_CRCREQ: stateNext = S_CRCACC;
         S_CRCACC: stateNext = atLast ? S_IDLE : S_CRCREQ;
         S_FUSE:   stateNext = S_IDLE;
         default:  stateNext = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stateReg <= S_IDLE;
         busy     <= 1'b0;
      end else begin
         stateReg <= stateNext;
         busy     <= (stateNext != S_IDLE); // [RULE7]
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         kindReg     <= OP_NONE;
         ptrReg      <= '0;
         firstReg    <= '0;
         lastReg     <= '0;
         fuseIdxReg  <= 3'h0;
         fuseDataReg <= 8'h00;
      end else if (start) begin
         kindReg     <= opKind;
         ptrReg      <= opPage ? pageFirst : opBase;
         firstReg    <= opPage ? pageFirst : opBase;
         lastReg     <= opPage ? pageFirst + PAGE_LAST : opLast;
         fuseIdxReg  <= (cmdReg == CMD_WR_LOCK) ? LOCK_IDX : dbgAddr[2:0];
         fuseDataReg <= dbgData;
      end else if (stateReg == S_ERASE && atLast) begin
         ptrReg <= firstReg;
      end else if (!atLast && (stateReg == S_ERASE || stateReg == S_BUFWR || stateReg == S_CRCACC)) begin
         ptrReg <= ptrReg + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // array port and page buffer
   // ---------------------------------------------------------------
   assign mem.wrEn   = (stateReg == S_ERASE) || (stateReg == S_BUFWR); // [RULE2] [RULE6]
   assign mem.wrData = (stateReg == S_ERASE) ? ERASED_BYTE : bufData; // [RULE3]
   assign mem.rdEn   = (stateReg == S_CRCREQ);
   assign mem.addr   = ptrReg;

   // buffer index trails the pointer by one cycle; data is used in the write step
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         bufIndex <= '0;
      end else begin
         bufIndex <= ptrReg[PAGE_AW-1:0]; // [RULE3]
      end
   end

   // ---------------------------------------------------------------
   // crc
   // ---------------------------------------------------------------
   function automatic logic [31:0] crcByte(input logic [31:0] crc, input logic [7:0] data);
      logic [31:0] c;
      c = crc ^ {24'h00_0000, data};
      for (int i = 0; i < 8; i++) begin
         c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction : crcByte

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         crcReg  <= CRC_INIT;
         dataReg <= DATA_RESET;
      end else if (start) begin
         crcReg <= CRC_INIT;
      end else if (stateReg == S_CRCACC) begin
         crcReg <= crcByte(crcReg, mem.rdData);
         if (atLast) begin
            dataReg <= ~crcByte(crcReg, mem.rdData); // [RULE9]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         memEnabled <= 1'b1;
      end else if (start && opFlash) begin
         memEnabled <= 1'b0; // [RULE11]
      end else if (doneEv) begin
         memEnabled <= 1'b1; // [RULE11] [RULE12]
      end
   end

   // ---------------------------------------------------------------
   // fuses and lock byte
   // ---------------------------------------------------------------
   // and-ing only clears bits, so nothing can be made less secure
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 8; i++) begin
            fuseReg[i] <= FUSE_RESET;
         end
      end else if (stateReg == S_FUSE) begin
         fuseReg[fuseIdxReg] <= fuseReg[fuseIdxReg] & fuseDataReg; // [RULE13]
      end
   end

   // ---------------------------------------------------------------
   // interrupt
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         intFlagReg <= INT_RESET;
         irq        <= 1'b0;
      end else begin
         // a set in the clearing cycle wins
         intFlagReg <= (intFlagReg & ~((apbWr && ofs == OFS_INTFLAG) ? pwdata[1:0] : 2'h0))
                       | {rejectEv, doneEv};
         irq        <= |(intFlagReg & intMaskReg);
      end
   end

endmodule : nvm_page_command_sequencer

// [sim/nvm_seq_properties.sv]
`timescale 1ns/10ps
module nvm_seq_properties (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic [15:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        dbgWrite,
   input wire logic        memEnabled,
   input wire logic        busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_one_wait: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
   a_ready_access: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_decode_err: assert property (pready && (paddr < 16'h01C0 || paddr > 16'h01DF) |-> pslverr)
      else $error("stray address accepted");
   a_busy_cause: assert property ($rose(busy) |-> $past(dbgWrite) || $past(pready))
      else $error("busy without trigger");
   a_exec_hold: assert property ($rose(busy) && $past(pready) |-> busy [*8])
      else $error("execute op too short");
   a_memen_busy: assert property (!memEnabled |-> busy) else $error("path cut while idle");
   a_memen_fall: assert property ($fell(memEnabled) |-> $rose(busy)) else $error("cut not at start");
   a_memen_rise: assert property ($rose(memEnabled) |-> $fell(busy)) else $error("path back early");
endmodule : nvm_seq_properties

bind nvm_page_command_sequencer nvm_seq_properties i_props (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .dbgWrite(dbgWrite),
   .memEnabled(memEnabled), .busy(busy));

// [sim/nvm_prog_model.sv]
`timescale 1ns/10ps
module nvm_prog_model (
   input wire logic        sys_clk,
   input wire logic [4:0]  bufIndex,
   input wire logic        memEnabled,
   output logic            dbgWrite,
   output logic [15:0]     dbgAddr,
   output logic [7:0]      dbgData,
   output logic [7:0]      bufData
);
   // page buffer holds a fixed function of the index
   assign bufData = {bufIndex, 3'b101};
   initial {dbgWrite, dbgAddr, dbgData} = 25'h000_0000;
   // command is loaded first; waits until the path is back
   task automatic poke(input logic [15:0] a, input logic [7:0] d);
      while (memEnabled !== 1'b1) @(posedge sys_clk);
      @(posedge sys_clk);
      dbgWrite <= 1'b1;
      dbgAddr  <= a;
      dbgData  <= d;
      @(posedge sys_clk);
      dbgWrite <= 1'b0;
      // released lines show the inverse
      dbgAddr  <= ~a;
      dbgData  <= ~d;
   endtask : poke
endmodule : nvm_prog_model

// [sim/nvm_page_command_sequencer_tb_top.sv]
`timescale 1ns/10ps
module nvm_page_command_sequencer_tb_top
   import nvm_seq_pkg::*;
;
   logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, progMode, e;
   logic        dbgWrite, memEnabled, busy, irq;
   logic [15:0] paddr, dbgAddr;
   logic [31:0] pwdata, prdata, r;
   logic [4:0]  bufIndex;
   logic [7:0]  dbgData, bufData;
   logic [7:0]  img [0:1279];
   int          badCount, nChecks, busyCnt;

   nvm_page_command_sequencer i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .progMode(progMode), .dbgWrite(dbgWrite), .dbgAddr(dbgAddr), .dbgData(dbgData),
      .bufIndex(bufIndex), .bufData(bufData), .memEnabled(memEnabled), .busy(busy), .irq(irq));
   nvm_prog_model i_prog (.sys_clk(sys_clk), .bufIndex(bufIndex), .memEnabled(memEnabled),
      .dbgWrite(dbgWrite), .dbgAddr(dbgAddr), .dbgData(dbgData), .bufData(bufData));

   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (busy === 1'b1) busyCnt <= busyCnt + 1;

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", nChecks, badCount);
      if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         badCount++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   function automatic logic [15:0] ra(input logic [4:0] o);
      return BASE_ADDR + {11'h000, o};
   endfunction : ra
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [4:0] o, input logic [31:0] exp);
      apb(1'b0, ra(o), 32'h0000_0000);
      cmp(r, exp);
   endtask : rd
   task automatic do_cmd(input logic [6:0] c, input logic ex, input logic [15:0] a, input logic [7:0] d,
                         input int n);
      apb(1'b1, ra(OFS_CMD), {25'h000_0000, c});
      busyCnt = 0;
      if (ex && !progMode) apb(1'b1, ra(OFS_CCP), 32'(CCP_KEY));
      if (ex) apb(1'b1, ra(OFS_MEMORY_CONTROL_A), 32'h0000_0001);
      else i_prog.poke(a, d);
      while (busy !== 1'b1) @(posedge sys_clk);
      cmp(32'(memEnabled), 32'(c != CMD_CRC_FLASH));
      while (busy !== 1'b0) @(posedge sys_clk);
      cmp(32'(busyCnt), 32'(n));
      repeat (2) @(posedge sys_clk);
      cmp(32'(irq), 32'h0000_0001);
      apb(1'b1, ra(OFS_INTFLAG), 32'h0000_0003);
   endtask : do_cmd
   // reference crc, low address first
   function automatic logic [31:0] crc_of(input int lo, input int hi);
      logic [31:0] c;
      c = CRC_INIT;
      for (int i = lo; i <= hi; i++) begin
         c = c ^ {24'h00_0000, img[i]};
         for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction : crc_of

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      {sys_clk, rst_b, psel, penable, pwrite, progMode} = 6'h00;
      {paddr, pwdata, badCount, nChecks, busyCnt} = '0;
      for (int i = 0; i < 1280; i++) img[i] = (i / 32 == 1 || i / 32 == 33) ? {i[4:0], 3'b101} : 8'hFF;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rd(OFS_STATUS, 32'h0000_FF02);
      rd(OFS_CMD, 32'h0000_0000);
      apb(1'b0, 16'h01E0, 32'h0000_0000);
      cmp(32'(e), 32'h0000_0001);
      apb(1'b1, ra(OFS_INTMASK), 32'h0000_0003);
      apb(1'b1, ra(OFS_ADDR), 32'h0000_0000);
      do_cmd(CMD_ER_APP_SEC, 1'b0, 16'h0100, 8'h00, 1024);
      do_cmd(CMD_ER_BOOT_SEC, 1'b0, 16'h0000, 8'h00, 256);
      do_cmd(CMD_ER_EEP_SEC, 1'b0, 16'h0000, 8'h00, 256);
      do_cmd(CMD_ER_APP_PG, 1'b1, 16'h0000, 8'h00, 32);
      do_cmd(CMD_ER_BOOT_PG, 1'b1, 16'h0000, 8'h00, 32);
      do_cmd(CMD_ER_EEP_PG, 1'b1, 16'h0000, 8'h00, 32);
      do_cmd(CMD_ER_USIG, 1'b1, 16'h0000, 8'h00, 32);
      do_cmd(CMD_WR_APP_PG, 1'b0, 16'h0025, 8'h00, 64);
      do_cmd(CMD_WR_BOOT_PG, 1'b0, 16'h003F, 8'h00, 64);
      do_cmd(CMD_WR_EEP_PG, 1'b0, 16'h0020, 8'h00, 64);
      do_cmd(CMD_WR_USIG, 1'b0, 16'h0000, 8'h00, 64);
      do_cmd(CMD_EW_APP_PG, 1'b0, 16'h0020, 8'h00, 96);
      do_cmd(CMD_EW_BOOT_PG, 1'b0, 16'h0031, 8'h00, 96);
      do_cmd(CMD_EW_EEP_PG, 1'b0, 16'h0020, 8'h00, 96);
      progMode <= 1'b1;
      do_cmd(CMD_CRC_APP, 1'b1, 16'h0000, 8'h00, 2048);
      rd(OFS_DATA, crc_of(0, 1023));
      progMode <= 1'b0;
      do_cmd(CMD_CRC_BOOT, 1'b1, 16'h0000, 8'h00, 512);
      rd(OFS_DATA, crc_of(1024, 1279));
      do_cmd(CMD_CRC_FLASH, 1'b1, 16'h0000, 8'h00, 2560);
      rd(OFS_DATA, crc_of(0, 1279));
      // locked crc refused; irq follows mask
      apb(1'b1, ra(OFS_INTMASK), 32'h0000_0001);
      apb(1'b1, ra(OFS_CMD), 32'h0000_0038);
      apb(1'b1, ra(OFS_MEMORY_CONTROL_A), 32'h0000_0001);
      rd(OFS_INTFLAG, 32'h0000_0002);
      cmp(32'(irq), 32'h0000_0000);
      apb(1'b1, ra(OFS_INTMASK), 32'h0000_0003);
      repeat (2) @(posedge sys_clk);
      cmp(32'(irq), 32'h0000_0001);
      apb(1'b1, ra(OFS_INTFLAG), 32'h0000_0002);
      repeat (2) @(posedge sys_clk);
      cmp(32'(irq), 32'h0000_0000);
      apb(1'b1, ra(OFS_ADDR), 32'h0000_0002);
      do_cmd(CMD_WR_FUSE, 1'b0, 16'h0002, 8'hF0, 1);
      rd(OFS_STATUS, 32'h0000_F002);
      do_cmd(CMD_WR_FUSE, 1'b0, 16'h0002, 8'h3C, 1);
      rd(OFS_STATUS, 32'h0000_3002);
      do_cmd(CMD_WR_LOCK, 1'b0, 16'h0007, 8'hFC, 1);
      apb(1'b1, ra(OFS_ADDR), 32'h0000_0007);
      rd(OFS_STATUS, 32'h0000_FC02);
      close_out();
   end
   // run takes some 8000 cycles
   initial begin
      repeat (30000) @(posedge sys_clk);
      badCount++;
      close_out();
   end
endmodule : nvm_page_command_sequencer_tb_top
